// [core/cmd_dec_consts.vh]
`ifndef CMD_DEC_CONSTS_VH
`define CMD_DEC_CONSTS_VH
// Command encodings.
`define CMD_STATUS_POLL 16'h0000
`define CMD_SOFT_RESET 16'h0011
`define CMD_LOW_POWER_ENTRY 16'h0022
`define CMD_LOW_POWER_EXIT 16'h0033
`define CMD_FREEZE 16'h0555
`define CMD_RELEASE 16'h0655
// Prefixes in the top three bits of a register access command.
`define PFX_READ 3'h1
`define PFX_WRITE 3'h2
`define PFX_MULTI_WRITE 3'h3
// Field positions inside the command word.
`define FLD_PFX 15:13
`define FLD_ADDR 12:8
`define FLD_BYTE 7:0
// Ready word upper byte.
`define READY_HI 8'hFF
// Number of registers that exist and the address of the primary fault status register.
`define REG_COUNT 6'h20
`define STAT_ADDR 5'h02
`endif

// [core/cmd_reg_mem.v]
`timescale 1ns/10ps
// Small register array with a registered read port and one write port.
module cmd_reg_mem #(
	parameter AW = 5,
	parameter DW = 8
) (
	input wire sys_clk,
	input wire srst,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	integer i;

	// Reset returns every register to its default of zero.
	always @(posedge sys_clk) begin
		if (srst) begin
			for (i = 0; i < (1<<AW); i = i + 1) begin
				mem[i] <= {DW{1'b0}};
			end
			rd_data <= {DW{1'b0}};
		end else begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// [core/cmd_sync.v]
`timescale 1ns/10ps
// Two flop synchroniser for one level from outside the clock domain.
module cmd_sync #(
	parameter RST_VAL = 1'b0
) (
	input wire sys_clk,
	input wire srst,
	input wire din,
	output reg dout
);
	reg meta_r;

	// Only the second flop is read by other logic.
	always @(posedge sys_clk) begin
		if (srst) begin
			meta_r <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule

// [core/spi_command_decoder.v]
`timescale 1ns/10ps
`include "cmd_dec_consts.vh"
module spi_command_decoder #(
	parameter WORD_BITS = 24,
	parameter [7:0] DEVICE_CODE = 8'h5A, // Arbitrary value of our own.
	parameter [7:0] FAULT_DEFAULT = 8'h00
) (
	input wire sys_clk,
	input wire srst,
	input wire cs_n,
	input wire sclk,
	input wire din,
	output reg dout,
	output reg dout_oe,
	output reg standby,
	output reg locked,
	output reg unconfigured,
	output reg cmd_done
);
	// One-hot decoder states.
	localparam ST_IDLE = 4'h1;
	localparam ST_DECODE = 4'h2;
	localparam ST_READ = 4'h4;
	localparam ST_BUILD = 4'h8;

	wire cs_s;
	wire sclk_s;
	wire din_s;
	reg sclk_d_r;
	reg cs_d_r;
	reg [3:0] st_r;
	reg [15:0] cmd_r;
	reg [15:0] resp_r;
	reg [WORD_BITS-1:0] tx_r;
	reg [15:0] rx_r;
	reg [5:0] bit_cnt_r;
	reg [8:0] word_cnt_r;
	reg [15:0] wr_word_r;
	reg [4:0] waddr_r;
	reg [8:0] wleft_r;
	reg mw_active_r;
	reg mw_phase_r;
	reg reset_pend_r;
	reg [4:0] raddr_r;
	reg [8:0] rleft_r;
	reg read_multi_r;
	reg data_word_r;
	reg [1:0] rd_wait_r;
	reg mem_we;
	reg [4:0] mem_waddr;
	reg [7:0] mem_wdata;
	wire [7:0] mem_rdata;
	wire sclk_rise;
	wire sclk_fall;
	wire frame_end;
	wire mw_ok;

	cmd_sync #(.RST_VAL(1'b1)) u_cs (.sys_clk(sys_clk), .srst(srst), .din(cs_n), .dout(cs_s));
	cmd_sync #(.RST_VAL(1'b0)) u_ck (.sys_clk(sys_clk), .srst(srst), .din(sclk), .dout(sclk_s));
	cmd_sync #(.RST_VAL(1'b0)) u_di (.sys_clk(sys_clk), .srst(srst), .din(din), .dout(din_s));

	cmd_reg_mem #(.AW(5), .DW(8)) u_mem (
		.sys_clk(sys_clk),
		.srst(srst | reset_pend_r),
		.wr_en(mem_we),
		.wr_addr(mem_waddr),
		.wr_data(mem_wdata),
		.rd_addr(raddr_r),
		.rd_data(mem_rdata)
	);

	assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_s;
	assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_s;
	assign frame_end = cs_s & ~cs_d_r;
	// Multi write data only land while the interface is open.
	assign mw_ok = (cmd_r[`FLD_PFX] == `PFX_MULTI_WRITE) && !locked && !unconfigured;

	// Recognised register access prefix test, fields at fixed positions.
	function is_access;
		input [15:0] c;
		begin
			is_access = (c[`FLD_PFX] == `PFX_READ) || (c[`FLD_PFX] == `PFX_WRITE) ||
				(c[`FLD_PFX] == `PFX_MULTI_WRITE);
		end
	endfunction

	// True when register index idx of a multi write is inside the count and the map.
	// Indices past the top of the map are dropped rather than wrapped onto address zero.
	function mw_hit;
		input [15:0] c;
		input [8:0] idx;
		begin
			mw_hit = (idx <= {1'b0, c[`FLD_BYTE]}) &&
				(({4'h0, c[`FLD_ADDR]} + idx) < {3'h0, `REG_COUNT});
		end
	endfunction

	// Serial data samples on the falling edge; words of WORD_BITS are counted.
	always @(posedge sys_clk) begin
		if (srst) begin
			sclk_d_r <= 1'b0;
			cs_d_r <= 1'b1;
			rx_r <= 16'h0000;
			bit_cnt_r <= 6'h00;
			word_cnt_r <= 9'h000;
			cmd_r <= `CMD_STATUS_POLL;
			wr_word_r <= 16'h0000;
			data_word_r <= 1'b0;
		end else begin
			data_word_r <= 1'b0;
			sclk_d_r <= sclk_s;
			cs_d_r <= cs_s;
			if (cs_s) begin
				bit_cnt_r <= 6'h00;
				word_cnt_r <= 9'h000;
			end else if (sclk_fall) begin
				if (bit_cnt_r < 6'h10) begin
					rx_r <= {rx_r[14:0], din_s};
				end
				if (bit_cnt_r == 6'h0F && word_cnt_r != 9'h000) begin
					data_word_r <= 1'b1;
				end
				if (bit_cnt_r == WORD_BITS - 1) begin
					bit_cnt_r <= 6'h00;
					word_cnt_r <= word_cnt_r + 9'h001;
				end else begin
					bit_cnt_r <= bit_cnt_r + 6'h01;
				end
			end
			if (~cs_s && bit_cnt_r == 6'd16 && word_cnt_r == 9'h000) begin
				cmd_r <= rx_r;
			end
			if (~cs_s && bit_cnt_r == 6'd16 && word_cnt_r != 9'h000) begin
				wr_word_r <= rx_r;
			end
		end
	end

	// Decoder and response builder.
	always @(posedge sys_clk) begin
		if (srst) begin
			st_r <= ST_IDLE;
			resp_r <= {`READY_HI, DEVICE_CODE};
			standby <= 1'b0;
			locked <= 1'b0;
			unconfigured <= 1'b1;
			cmd_done <= 1'b0;
			reset_pend_r <= 1'b0;
			raddr_r <= 5'h00;
			rleft_r <= 9'h000;
			read_multi_r <= 1'b0;
			rd_wait_r <= 2'h0;
			mw_active_r <= 1'b0;
			mw_phase_r <= 1'b0;
			waddr_r <= 5'h00;
			wleft_r <= 9'h000;
		end else begin
			cmd_done <= 1'b0;
			reset_pend_r <= 1'b0;
			// two writes per word
			// Writes land as each data word arrives, so a cut frame keeps its early registers.
			mw_phase_r <= data_word_r;
			mw_active_r <= mw_phase_r;
			if (data_word_r) begin
				wleft_r <= {word_cnt_r[7:0] - 8'h01, 1'b0};
				waddr_r <= cmd_r[`FLD_ADDR] + {word_cnt_r[3:0] - 4'h1, 1'b0};
			end
			case (st_r)
				ST_IDLE: begin
					if (frame_end) begin
						st_r <= ST_DECODE;
					end
				end
				ST_DECODE: begin
					st_r <= ST_IDLE;
					cmd_done <= 1'b1;
					raddr_r <= cmd_r[`FLD_ADDR];
					if (cmd_r == `CMD_SOFT_RESET && !locked && !unconfigured) begin
						reset_pend_r <= 1'b1;
						standby <= 1'b0;
						unconfigured <= 1'b1;
						resp_r <= {`READY_HI, DEVICE_CODE};
					end else if (cmd_r == `CMD_RELEASE) begin
						locked <= 1'b0;
						unconfigured <= 1'b0;
						resp_r <= cmd_r;
					end else if (unconfigured) begin
						resp_r <= {`READY_HI, DEVICE_CODE};
					end else if (cmd_r == `CMD_STATUS_POLL) begin
						raddr_r <= `STAT_ADDR;
						read_multi_r <= 1'b0;
						rd_wait_r <= 2'h2;
						st_r <= ST_READ;
					end else if (locked && cmd_r[`FLD_PFX] != `PFX_READ) begin
						resp_r <= resp_r;
					end else if (cmd_r == `CMD_LOW_POWER_ENTRY) begin
						standby <= 1'b1;
						resp_r <= cmd_r;
					end else if (cmd_r == `CMD_LOW_POWER_EXIT) begin
						standby <= 1'b0;
						resp_r <= cmd_r;
					end else if (cmd_r == `CMD_FREEZE) begin
						locked <= 1'b1;
						resp_r <= cmd_r;
					end else if (is_access(cmd_r)) begin
						if (cmd_r[`FLD_PFX] == `PFX_READ) begin
							read_multi_r <= (cmd_r[`FLD_BYTE] != 8'h00);
							rleft_r <= {1'b0, cmd_r[`FLD_BYTE]};
							rd_wait_r <= 2'h2;
							st_r <= ST_READ;
						end else if (cmd_r[`FLD_PFX] == `PFX_WRITE) begin
							rd_wait_r <= 2'h2;
							read_multi_r <= 1'b0;
							st_r <= ST_READ;
						end else begin
							resp_r <= {`PFX_WRITE, cmd_r[12:0]};
						end
					end
				end
				ST_READ: begin
					// Memory read data lag the address by one clock.
					if (rd_wait_r != 2'h0) begin
						rd_wait_r <= rd_wait_r - 2'h1;
					end else begin
						st_r <= ST_IDLE;
						if (read_multi_r) begin
							resp_r <= {`PFX_MULTI_WRITE, cmd_r[12:0]};
						end else begin
							resp_r <= {`PFX_READ, raddr_r, mem_rdata};
						end
					end
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Register writes: single write at decode, multi write per received data word.
	always @* begin
		mem_we = 1'b0;
		mem_waddr = cmd_r[`FLD_ADDR];
		mem_wdata = cmd_r[`FLD_BYTE];
		if (st_r == ST_DECODE && !locked && !unconfigured &&
			cmd_r[`FLD_PFX] == `PFX_WRITE) begin
			mem_we = 1'b1;
		end else if (mw_phase_r && mw_ok && mw_hit(cmd_r, wleft_r)) begin
			// Upper byte of a data word goes to the lower-addressed register of the pair.
			mem_we = 1'b1;
			mem_waddr = waddr_r;
			mem_wdata = wr_word_r[15:8];
		end else if (mw_active_r && mw_ok && mw_hit(cmd_r, wleft_r + 9'h001)) begin
			mem_we = 1'b1;
			mem_waddr = waddr_r + 5'h01;
			mem_wdata = wr_word_r[7:0];
		end
	end

	always @(posedge sys_clk) begin
		if (srst) begin
			tx_r <= {WORD_BITS{1'b0}};
			dout <= 1'b0;
			dout_oe <= 1'b0;
		end else begin
			dout_oe <= ~cs_s;
			if (cs_s) begin
				tx_r <= {resp_r, {(WORD_BITS-16){1'b0}}};
			end else if (sclk_rise) begin
				dout <= tx_r[WORD_BITS-1];
				tx_r <= {tx_r[WORD_BITS-2:0], 1'b0};
			end
		end
	end
endmodule

// [testbench/spi_cmd_checker.sv]
`timescale 1ns/10ps
// Port-level checks on frame select handling, decode timing and mode levels.
module spi_cmd_checker #(
	parameter WORD_BITS = 24
) (
	input wire sys_clk,
	input wire srst,
	input wire cs_n,
	input wire dout_oe,
	input wire standby,
	input wire locked,
	input wire unconfigured,
	input wire cmd_done
);
	// One clock domain, so clocking and reset are given once.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	property p_oe_on; (!cs_n) [*4] |-> dout_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("output enable missing in frame");
	property p_oe_off; cs_n [*4] |-> !dout_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("output enabled between frames");
	property p_decode; $rose(cs_n) |-> ##[1:12] cmd_done; endproperty
	a_decode: assert property (p_decode) else $error("no decode after frame end");
	property p_done_pos; cmd_done |-> cs_n && $past(cs_n, 2); endproperty
	a_done_pos: assert property (p_done_pos) else $error("decode inside a frame");
	property p_lock; !$stable(locked) |-> cmd_done || $past(cmd_done); endproperty
	a_lock: assert property (p_lock) else $error("lock level moved without decode");
	property p_stby; !$stable(standby) |-> cmd_done || $past(cmd_done); endproperty
	a_stby: assert property (p_stby) else $error("standby moved without decode");
	property p_unc; !$stable(unconfigured) |-> cmd_done || $past(cmd_done); endproperty
	a_unc: assert property (p_unc) else $error("unconfigured moved without decode");
	property p_rst; $fell(srst) |-> unconfigured && !locked; endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule
bind spi_command_decoder spi_cmd_checker #(.WORD_BITS(WORD_BITS)) chk_inst(.sys_clk(sys_clk),
	.srst(srst), .cs_n(cs_n), .dout_oe(dout_oe), .standby(standby), .locked(locked),
	.unconfigured(unconfigured), .cmd_done(cmd_done));

// [testbench/spi_host.sv]
`timescale 1ns/10ps
// Serial host: link clock stands low between frames, half period of 4 system clocks.
module spi_host #(
	parameter WORD_BITS = 24
) (
	input wire sys_clk,
	output reg cs_n,
	output reg sclk,
	output reg din,
	input wire dout
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	// Changes land just after a system clock edge.
	task half;
		begin
			repeat (4) @(posedge sys_clk);
			#1;
		end
	endtask
	// One frame of w words; r is the first 16 bits read back, low the rest of word 0.
	task xfer(input [15:0] c, input [15:0] d, input integer w, output [15:0] r,
		output [15:0] low);
		integer i;
		begin
			r = 16'h0000;
			low = 16'h0000;
			@(posedge sys_clk);
			#1 cs_n = 1'b0;
			half;
			for (i = 0; i < WORD_BITS * w; i = i + 1) begin
				// Both lines move on the rising edge; the decoder samples on the falling one.
				sclk = 1'b1;
				if (i < WORD_BITS)
					din = (i < 16) ? c[15 - i] : 1'b0;
				else
					din = ((i % WORD_BITS) < 16) ? d[15 - (i % WORD_BITS)] : 1'b0;
				half;
				if (i < 16)
					r = {r[14:0], dout};
				else if (i < WORD_BITS)
					low = {low[14:0], dout};
				sclk = 1'b0;
				half;
			end
			cs_n = 1'b1;
			din = ~din; // Released line no longer shows the last bit.
		end
	endtask
endmodule

// [testbench/test_spi_command_decoder.sv]
`timescale 1ns/10ps
// Drives command frames and compares responses and levels with a behavioural model.
module test_spi_command_decoder;
	localparam [7:0] DEV = 8'h5A; // Arbitrary device code.
	reg sys_clk = 1'b0;
	reg srst = 1'b1;
	wire cs_n, sclk, din, dout, dout_oe, standby, locked, unconfigured, cmd_done;
	integer err_count = 0;
	integer compares = 0;
	integer k;
	reg [31:0] seed = 32'hf3617d1e;
	reg [15:0] resp, exp_r, low_bits, wdata;
	reg [7:0] mem [0:31];
	reg [4:0] a;
	reg m_unc, m_lock, m_stby;
	// Clock of 40 ns period.
	initial forever #20 sys_clk = ~sys_clk;
	spi_command_decoder #(.WORD_BITS(24), .DEVICE_CODE(DEV), .FAULT_DEFAULT(8'h00))
	spi_command_decoder_inst(.sys_clk(sys_clk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
		.din(din), .dout(dout), .dout_oe(dout_oe), .standby(standby), .locked(locked),
		.unconfigured(unconfigured), .cmd_done(cmd_done));
	spi_host #(.WORD_BITS(24)) spi_host_inst(.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk),
		.din(din), .dout(dout));
	task check(input [8*8-1:0] name, input [15:0] seen, input [15:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("mismatches %0d comparisons %0d", err_count, compares);
			if (err_count == 0 && compares > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// Model of the decoder: sets the response expected in the next frame.
	task model(input [15:0] c, input integer w);
		integer j;
		begin
			if (m_unc) begin
				m_unc = (c != 16'h0655);
				exp_r = m_unc ? {8'hFF, DEV} : c;
			end else if (m_lock && !(c == 16'h0 || c == 16'h0655 || c[15:13] == 3'h1))
				exp_r = exp_r; // Locked: the command is ignored and the response kept.
			else if (c == 16'h0)
				exp_r = {8'h22, mem[2]};
			else if (c == 16'h0011) begin
				m_unc = 1'b1;
				m_stby = 1'b0;
				for (j = 0; j < 32; j = j + 1)
					mem[j] = 8'h00;
				exp_r = {8'hFF, DEV};
			end else if (c == 16'h0022 || c == 16'h0033 || c == 16'h0555 || c == 16'h0655) begin
				m_stby = (c == 16'h0022) ? 1'b1 : (c == 16'h0033) ? 1'b0 : m_stby;
				m_lock = (c == 16'h0555);
				exp_r = c;
			end else if (c[15:13] == 3'h1)
				exp_r = (c[7:0] == 8'h00) ? {3'h1, c[12:8], mem[c[12:8]]} : {3'h3, c[12:0]};
			else if (c[15:13] == 3'h2) begin
				mem[c[12:8]] = c[7:0];
				exp_r = {3'h1, c[12:0]};
			end else if (c[15:13] == 3'h3) begin
				// Two registers per extra word, within the count and the map.
				for (j = 0; j < 2 * (w - 1); j = j + 1)
					if (j <= c[7:0] && c[12:8] + j < 32)
						mem[c[12:8] + j] = (j % 2) ? wdata[7:0] : wdata[15:8];
				exp_r = {3'h2, c[12:0]};
			end
		end
	endtask
	// One frame, then the gap between frames and a look at the mode levels.
	task run(input [15:0] c, input integer w);
		begin
			spi_host_inst.xfer(c, wdata, w, resp, low_bits);
			check("response", resp, exp_r);
			check("lowbits", low_bits, 16'h0000);
			model(c, w);
			repeat (20) @(posedge sys_clk);
			#1;
			check("levels", {13'h0, unconfigured, locked, standby},
				{13'h0, m_unc, m_lock, m_stby});
		end
	endtask
	// Main sequence.
	initial begin
		m_unc = 1'b1;
		m_lock = 1'b0;
		m_stby = 1'b0;
		exp_r = {8'hFF, DEV};
		wdata = 16'h0000;
		for (k = 0; k < 32; k = k + 1)
			mem[k] = 8'h00;
		repeat (10) @(posedge sys_clk);
		#1 srst = 1'b0;
		repeat (5) @(posedge sys_clk);
		run(16'h0000, 1);
		run(16'h4312, 1);
		run(16'h0655, 1);
		run(16'h0022, 1);
		run(16'h0033, 1);
		run(16'h0000, 1);
		// Random writes each followed by a read back of the same place.
		for (k = 0; k < 6; k = k + 1) begin
			seed = seed ^ (seed << 13);
			seed = seed ^ (seed >> 17);
			seed = seed ^ (seed << 5);
			a = (seed[12:8] == 5'h02) ? 5'h03 : seed[12:8];
			run({3'h2, a, seed[7:0]}, 1);
			run({3'h1, a, 8'h00}, 1);
		end
		run({3'h1, 5'h04, 8'h03}, 1);
		// count of two adds one word
		wdata = 16'h9E47;
		run({3'h3, 5'h05, 8'h02}, 2);
		run({3'h1, 5'h05, 8'h00}, 1);
		run({3'h1, 5'h06, 8'h00}, 1);
		run({3'h1, 5'h07, 8'h00}, 1);
		run(16'h0022, 1);
		// A reset in mid-run brings back the power-on state and the ready word.
		@(posedge sys_clk);
		#1 srst = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 srst = 1'b0;
		m_unc = 1'b1;
		m_lock = 1'b0;
		m_stby = 1'b0;
		exp_r = {8'hFF, DEV};
		for (k = 0; k < 32; k = k + 1)
			mem[k] = 8'h00;
		repeat (5) @(posedge sys_clk);
		run(16'h0655, 1);
		run(16'h1234, 1);
		run({3'h2, 5'h06, 8'h3C}, 1);
		run(16'h0555, 1);
		run({3'h2, 5'h06, 8'hA5}, 1);
		run({3'h1, 5'h06, 8'h00}, 1);
		run(16'h0655, 1);
		run(16'h0011, 1);
		run(16'h0000, 1);
		tally_and_finish;
	end
	// A hang ends the run as a failure.
	initial begin
		#800000;
		err_count = err_count + 1;
		tally_and_finish;
	end
endmodule
